/* File: core/hws_pkg.sv */
// shared constants and types for the haptic waveform sequencer
package hws_pkg;
  localparam logic [7:0] ADDR_LIB_CTRL = 8'h03;
  localparam logic [7:0] ADDR_SLOT_FIRST = 8'h04;
  localparam logic [7:0] ADDR_SLOT_LAST = 8'h0b;
  localparam logic [7:0] ADDR_GO = 8'h0c;
  localparam int FLOAT_BIT = 4;
  localparam int GO_BIT = 0;
  localparam int WAIT_BIT = 7;
  localparam logic [7:0] LIB_CTRL_RESET = 8'h01;
  localparam logic [7:0] LIB_CTRL_MASK = 8'h17;
  localparam logic [7:0] SLOT_RESET = 8'h00;
  localparam logic [2:0] LIB_EMPTY = 3'h0;
  localparam logic [2:0] LIB_LRA = 3'h6;
  localparam logic [2:0] LIB_RESERVED = 3'h7;
  localparam logic [2:0] SLOT_IDX_LAST = 3'h7;
  localparam int NUM_SLOTS = 8;
  localparam int CLK_HZ = 20_000_000;
  localparam int WAIT_UNIT_MS = 10;
  localparam int WAIT_UNIT_CYCLES = WAIT_UNIT_MS * (CLK_HZ / 1000);
  localparam int TICK_W = 18;
  // bus target address, arbitrary value
  localparam logic [6:0] BUS_DEV_ADDR = 7'h2d;
  localparam logic [3:0] BIT_CNT_BYTE = 4'h8;
  localparam logic [3:0] BIT_CNT_LAST = 4'h7;

  typedef struct packed
  {
    logic valid;
    logic [7:0] addr;
    logic [7:0] data;
  } reg_wr_t;

  typedef struct packed
  {
    logic start;
    logic abort;
    logic [2:0] lib;
    logic [6:0] id;
  } play_cmd_t;

  typedef enum logic [3:0]
  {
    BS_IDLE = 4'h0,
    BS_DEV = 4'h1,
    BS_DEV_ACK = 4'h3,
    BS_PTR = 4'h2,
    BS_PTR_ACK = 4'h6,
    BS_WR = 4'h7,
    BS_WR_ACK = 4'h5,
    BS_RD = 4'h4,
    BS_RD_ACK = 4'hc
  } bus_state_t;

  typedef enum logic [1:0]
  {
    SQ_IDLE = 2'h0,
    SQ_FETCH = 2'h1,
    SQ_PLAY = 2'h3,
    SQ_WAIT = 2'h2
  } seq_state_t;
endpackage : hws_pkg

/* File: core/hws_bus_target.sv */
// serial two-wire register target with auto-incrementing pointer
module hws_bus_target
  import hws_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic [7:0] rd_data_in,
  output logic sda_out,
  output logic sda_oe_b_out,
  output logic [7:0] rd_addr_out,
  output reg_wr_t wr_out
);
  bus_state_t state_reg;
  logic scl_reg;
  logic sda_reg;
  logic [7:0] shift_reg;
  logic [3:0] cnt_reg;
  logic read_reg;
  logic ack_reg;
  wire start_seen = scl_in && scl_reg && sda_reg && !sda_in;
  wire stop_seen = scl_in && scl_reg && !sda_reg && sda_in;
  wire rise = scl_in && !scl_reg;
  wire fall = !scl_in && scl_reg;
  wire byte_in = (cnt_reg == BIT_CNT_BYTE);
  wire addr_hit = (shift_reg[7:1] == BUS_DEV_ADDR);
  wire receiving = (state_reg == BS_DEV) || (state_reg == BS_PTR) || (state_reg == BS_WR);

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      scl_reg <= 1'b1;
      sda_reg <= 1'b1;
    end
    else
    begin
      scl_reg <= scl_in;
      sda_reg <= sda_in;
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      state_reg <= BS_IDLE;
      shift_reg <= 8'h00;
      cnt_reg <= 4'h0;
      read_reg <= 1'b0;
      ack_reg <= 1'b0;
      sda_out <= 1'b0;
      sda_oe_b_out <= 1'b1;
      rd_addr_out <= 8'h00;
      wr_out <= '0;
    end
    else
    begin
      wr_out.valid <= 1'b0;
      sda_out <= 1'b0;
      if (start_seen)
      begin
        state_reg <= BS_DEV;
        cnt_reg <= 4'h0;
        sda_oe_b_out <= 1'b1;
      end
      else if (stop_seen)
      begin
        state_reg <= BS_IDLE;
        sda_oe_b_out <= 1'b1;
      end
      else if (receiving && rise && !byte_in)
      begin
        shift_reg <= {shift_reg[6:0], sda_in};
        cnt_reg <= cnt_reg + 4'h1;
      end
      else if (receiving && fall && byte_in)
      begin
        cnt_reg <= 4'h0;
        sda_oe_b_out <= 1'b0;
        case (state_reg)
          BS_DEV:
          begin
            read_reg <= shift_reg[0];
            sda_oe_b_out <= !addr_hit;
            state_reg <= addr_hit ? BS_DEV_ACK : BS_IDLE;
          end
          BS_PTR:
          begin
            rd_addr_out <= shift_reg;
            state_reg <= BS_PTR_ACK;
          end
          default:
          begin
            wr_out <= '{valid: 1'b1, addr: rd_addr_out, data: shift_reg};
            rd_addr_out <= rd_addr_out + 8'h01;
            state_reg <= BS_WR_ACK;
          end
        endcase
      end
      else if (fall)
      begin
        case (state_reg)
          BS_DEV_ACK:
          begin
            shift_reg <= rd_data_in;
            sda_oe_b_out <= read_reg ? rd_data_in[7] : 1'b1;
            state_reg <= read_reg ? BS_RD : BS_PTR;
          end
          BS_PTR_ACK, BS_WR_ACK:
          begin
            sda_oe_b_out <= 1'b1;
            state_reg <= BS_WR;
          end
          BS_RD:
          begin
            if (cnt_reg == BIT_CNT_LAST)
            begin
              sda_oe_b_out <= 1'b1;
              rd_addr_out <= rd_addr_out + 8'h01;
              state_reg <= BS_RD_ACK;
            end
            else
            begin
              sda_oe_b_out <= shift_reg[6];
              shift_reg <= {shift_reg[6:0], 1'b0};
              cnt_reg <= cnt_reg + 4'h1;
            end
          end
          BS_RD_ACK:
          begin
            // a missing acknowledge ends the read burst
            cnt_reg <= 4'h0;
            shift_reg <= rd_data_in;
            sda_oe_b_out <= ack_reg ? rd_data_in[7] : 1'b1;
            state_reg <= ack_reg ? BS_RD : BS_IDLE;
          end
          default:
          begin
            state_reg <= state_reg;
          end
        endcase
      end
      else if (rise && state_reg == BS_RD_ACK)
      begin
        ack_reg <= !sda_in;
      end
    end
  end
endmodule : hws_bus_target

/* File: core/haptic_waveform_sequencer.sv */
// library select, output float and eight-slot waveform sequencer
//
// Function
// - Bit 4 of the library control register floats the actuator output driver.
// - The float only takes hold while the device is enabled.
// - Raising the float at once cancels any sequence in progress.
// - The 3-bit library selector, reset to 1, picks the library latched when playback starts.
// - Selector 0 is the empty library, 1 to 5 the rotating-mass ones, 6 the resonant one, 7 reserved.
// - Slot bit 7 marks the slot as a timed wait instead of a waveform.
// - A wait slot idles for ten milliseconds times its 7-bit value.
// - A slot with bit 7 clear carries a 7-bit waveform identifier.
// - The identifier is passed on as the index into the chosen library.
// - Setting go starts the sequence at the slot at address 0x04.
// - After each slot the next address is taken, and played only when non-zero.
// - The sequence ends at the first zero slot or after the slot at 0x0b.
// - Go stays set until the sequence ends, and clearing it cancels the rest.
module haptic_waveform_sequencer
  import hws_pkg::*;
#(
  parameter int WAIT_UNIT_CYC = WAIT_UNIT_CYCLES
)
(
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic enable_in,
  input wire logic play_done_in,
  output logic sda_out,
  output logic sda_oe_b_out,
  output logic out_float_out,
  output logic busy_out,
  output play_cmd_t play_cmd_out
);
  function automatic logic slot_hit(input logic [7:0] addr);
    slot_hit = (addr >= ADDR_SLOT_FIRST) && (addr <= ADDR_SLOT_LAST);
  endfunction : slot_hit

  function automatic logic [2:0] slot_index(input logic [7:0] addr);
    slot_index = 3'(addr[2:0] - ADDR_SLOT_FIRST[2:0]);
  endfunction : slot_index

  reg_wr_t wr;
  logic [7:0] rd_addr;
  logic [7:0] rd_data;
  logic [7:0] lib_ctrl_reg;
  logic go_reg;
  logic go_next;
  logic [7:0] slot_reg [NUM_SLOTS];
  seq_state_t state_reg;
  seq_state_t state_next;
  logic [2:0] idx_reg;
  logic [2:0] idx_next;
  logic [2:0] lib_reg;
  logic [6:0] wait_left_reg;
  logic [6:0] wait_left_next;
  logic [TICK_W-1:0] tick_reg;
  logic [TICK_W-1:0] tick_next;
  logic seq_start;
  logic seq_finish;
  logic seq_abort;
  logic play_start;
  play_cmd_t play_cmd_next;

  // scl and sda taken as synchronous, no synchroniser in front
  hws_bus_target u_bus
  (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .rd_data_in(rd_data),
    .sda_out(sda_out),
    .sda_oe_b_out(sda_oe_b_out),
    .rd_addr_out(rd_addr),
    .wr_out(wr)
  );

  wire wr_lib = wr.valid && (wr.addr == ADDR_LIB_CTRL);
  wire wr_go = wr.valid && (wr.addr == ADDR_GO);
  wire wr_slot = wr.valid && slot_hit(wr.addr);
  wire float_active = lib_ctrl_reg[FLOAT_BIT] && enable_in;
  wire active = (state_reg != SQ_IDLE);
  wire float_abort = float_active && active;
  wire [7:0] cur_slot = slot_reg[idx_reg];
  wire slot_is_wait = cur_slot[WAIT_BIT];
  wire slot_empty = (cur_slot == 8'h00);
  wire [6:0] slot_value = cur_slot[6:0];
  wire last_slot = (idx_reg == SLOT_IDX_LAST);
  wire lib_silent = (lib_reg == LIB_EMPTY) || (lib_reg == LIB_RESERVED);
  wire tick_wrap = (tick_reg == TICK_W'(WAIT_UNIT_CYC - 1));
  wire wait_over = (wait_left_reg == 7'h00);
  // one shared tick keeps each wait unit exact to the cycle
  wire [TICK_W-1:0] tick_step = tick_wrap ? '0 : tick_reg + 1'b1;
  wire [6:0] wait_step = tick_wrap ? wait_left_reg - 7'h01 : wait_left_reg;
  // software clear or float ends a running sequence
  wire cancel = active && (!go_reg || float_active);

  wire rd_sel_lib = (rd_addr == ADDR_LIB_CTRL);
  wire rd_sel_go = (rd_addr == ADDR_GO);
  wire rd_sel_slot = slot_hit(rd_addr);
  wire [7:0] rd_slot_val = slot_reg[slot_index(rd_addr)];
  assign rd_data = rd_sel_lib ? (lib_ctrl_reg & LIB_CTRL_MASK) :
                   rd_sel_go ? {7'h00, go_reg} :
                   rd_sel_slot ? rd_slot_val : 8'h00;

  wire go_wr_val = wr.data[GO_BIT];
  // write wins over the self-clear
  // go written while floating stays pending until the float drops
  assign go_next = wr_go ? go_wr_val :
                   (seq_finish || float_abort) ? 1'b0 : go_reg;

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      lib_ctrl_reg <= LIB_CTRL_RESET;
      go_reg <= 1'b0;
    end
    else
    begin
      if (wr_lib)
      begin
        lib_ctrl_reg <= wr.data & LIB_CTRL_MASK;
      end
      go_reg <= go_next;
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      for (int i = 0; i < NUM_SLOTS; i++)
      begin
        slot_reg[i] <= SLOT_RESET;
      end
    end
    // a slot rewritten mid-sequence is used at its next fetch
    else if (wr_slot)
    begin
      slot_reg[slot_index(wr.addr)] <= wr.data;
    end
  end

  always_comb
  begin
    state_next = state_reg;
    idx_next = idx_reg;
    wait_left_next = wait_left_reg;
    tick_next = tick_reg;
    seq_start = 1'b0;
    seq_finish = 1'b0;
    seq_abort = 1'b0;
    play_start = 1'b0;
    case (state_reg)
      SQ_IDLE:
      begin
        if (go_reg && !float_active)
        begin
          seq_start = 1'b1;
          idx_next = 3'h0;
          state_next = SQ_FETCH;
        end
      end
      SQ_FETCH:
      begin
        if (slot_empty)
        begin
          seq_finish = 1'b1;
        end
        else if (slot_is_wait)
        begin
          wait_left_next = slot_value;
          tick_next = '0;
          state_next = SQ_WAIT;
        end
        // waveform slot, silent library skips it
        else if (lib_silent)
        begin
          state_next = SQ_WAIT;
          wait_left_next = 7'h00;
        end
        else
        begin
          play_start = 1'b1;
          state_next = SQ_PLAY;
        end
      end
      SQ_PLAY:
      begin
        if (play_done_in)
        begin
          state_next = SQ_WAIT;
          wait_left_next = 7'h00;
        end
      end
      SQ_WAIT:
      begin
        if (!wait_over)
        begin
          tick_next = tick_step;
          wait_left_next = wait_step;
        end
        else if (last_slot)
        begin
          seq_finish = 1'b1;
        end
        else
        begin
          idx_next = idx_reg + 3'h1;
          state_next = SQ_FETCH;
        end
      end
      default:
      begin
        state_next = SQ_IDLE;
      end
    endcase
    if (seq_finish)
    begin
      state_next = SQ_IDLE;
    end
    if (cancel)
    begin
      seq_abort = 1'b1;
      seq_finish = 1'b0;
      play_start = 1'b0;
      state_next = SQ_IDLE;
    end
  end

  // abort reaches the engine only while a waveform plays
  // identifier indexes the library
  assign play_cmd_next = '{start: play_start, abort: seq_abort && (state_reg == SQ_PLAY),
                           lib: lib_reg, id: slot_value};

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      state_reg <= SQ_IDLE;
      idx_reg <= 3'h0;
      wait_left_reg <= 7'h00;
      tick_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
      idx_reg <= idx_next;
      wait_left_reg <= wait_left_next;
      tick_reg <= tick_next;
    end
  end

  // latched so a mid-sequence write cannot swap libraries
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      lib_reg <= LIB_CTRL_RESET[2:0];
    end
    else if (seq_start)
    begin
      lib_reg <= lib_ctrl_reg[2:0];
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      out_float_out <= 1'b0;
      busy_out <= 1'b0;
      play_cmd_out <= '0;
    end
    else
    begin
      out_float_out <= float_active;
      // from the next state so busy drops in the same cycle as state_reg
      busy_out <= (state_next != SQ_IDLE);
      play_cmd_out <= play_cmd_next;
    end
  end
endmodule : haptic_waveform_sequencer

/* File: tb/hws_checker.sv */
// port assertions for the waveform sequencer
module hws_checker
  import hws_pkg::*;
#(
  parameter int WAIT_UNIT_CYC = WAIT_UNIT_CYCLES
)
(
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic enable_in,
  input wire logic play_done_in,
  input wire logic sda_out,
  input wire logic sda_oe_b_out,
  input wire logic out_float_out,
  input wire logic busy_out,
  input wire play_cmd_t play_cmd_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] starts_reg;
  // count restarts with every busy period
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      starts_reg <= 4'h0;
    else
      starts_reg <= busy_out ? starts_reg + 4'(play_cmd_out.start) : 4'h0;
  end
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_b_in);
  chk_float_enable: assert property (out_float_out |-> $past(enable_in))
    else $error("float seen without enable");
  chk_float_drop: assert property (!enable_in |=> !out_float_out)
    else $error("float kept while disabled");
  chk_float_cancel: assert property (out_float_out |=> !busy_out)
    else $error("sequence runs while floating");
  chk_start_busy: assert property (play_cmd_out.start |-> busy_out)
    else $error("start outside a sequence");
  chk_start_pulse: assert property (play_cmd_out.start |=> !play_cmd_out.start)
    else $error("start longer than one cycle");
  chk_start_lib: assert property (play_cmd_out.start |-> play_cmd_out.lib != LIB_EMPTY &&
    play_cmd_out.lib != LIB_RESERVED && play_cmd_out.id != 7'h00) else $error("bad start command");
  chk_done_gap: assert property (play_done_in |=> !play_cmd_out.start [*2])
    else $error("next start too soon");
  chk_abort_idle: assert property (play_cmd_out.abort |=> !busy_out)
    else $error("busy after abort");
  chk_slot_count: assert property (starts_reg <= 4'(NUM_SLOTS))
    else $error("more starts than slots");
  cover property (play_cmd_out.start);
  cover property (play_cmd_out.abort);
  cover property ($rose(out_float_out));
endmodule : hws_checker

bind haptic_waveform_sequencer hws_checker #(.WAIT_UNIT_CYC(WAIT_UNIT_CYC)) chk (.clk_in(clk_in),
  .rst_b_in(rst_b_in), .scl_in(scl_in), .sda_in(sda_in), .enable_in(enable_in), .play_done_in(play_done_in),
  .sda_out(sda_out), .sda_oe_b_out(sda_oe_b_out), .out_float_out(out_float_out), .busy_out(busy_out),
  .play_cmd_out(play_cmd_out));

/* File: tb/hws_host.sv */
// two-wire bus host model
module hws_host
  import hws_pkg::*;
(
  input wire logic clk_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_rel_out
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    scl_out = 1'b1;
    sda_rel_out = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask : tick
  // phases of 4 clocks, above the 3 the target needs
  task automatic xbit(input logic b, output logic r);
    sda_rel_out = b;
    tick(4);
    scl_out = 1'b1;
    tick(2);
    r = sda_in;
    tick(2);
    scl_out = 1'b0;
    tick(1);
  endtask : xbit
  task automatic xbyte(input logic [7:0] d, input logic a, output logic [7:0] q, output logic k);
    for (int i = 7; i >= 0; i--)
      xbit(d[i], q[i]);
    xbit(a, k);
  endtask : xbyte
  // start when stop is 0, stop when 1
  task automatic cond(input logic stop);
    sda_rel_out = ~stop;
    tick(4);
    scl_out = 1'b1;
    tick(4);
    sda_rel_out = stop;
    tick(4);
    scl_out = stop;
    tick(1);
  endtask : cond
  task automatic wr(input logic [6:0] dev, input logic [7:0] a, input logic [7:0] d, output logic ok);
    logic [7:0] q;
    logic k0, k1, k2;
    cond(1'b0);
    xbyte({dev, 1'b0}, 1'b1, q, k0);
    xbyte(a, 1'b1, q, k1);
    xbyte(d, 1'b1, q, k2);
    cond(1'b1);
    ok = ~(k0 | k1 | k2);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
    logic [7:0] q;
    logic k0, k1, k2, n;
    cond(1'b0);
    xbyte({BUS_DEV_ADDR, 1'b0}, 1'b1, q, k0);
    xbyte(a, 1'b1, q, k1);
    cond(1'b0);
    xbyte({BUS_DEV_ADDR, 1'b1}, 1'b1, q, k2);
    xbyte(8'hff, 1'b1, d, n);
    cond(1'b1);
    ok = ~(k0 | k1 | k2);
  endtask : rd
endmodule : hws_host

/* File: tb/haptic_waveform_sequencer_tb_top.sv */
// self-checking bench for the waveform sequencer
module haptic_waveform_sequencer_tb_top
  import hws_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int W = 8;
  logic clk_in, rst_b_in, enable_in, play_done_in, scl, sda_rel, sda_w, ok;
  logic sda_out, sda_oe_b_out, out_float_out, busy_out;
  play_cmd_t play_cmd_out, last_cmd;
  int err_count, n_checks, cyc, n_start, n_abort, dly, done_dly, t0, t1;
  logic [7:0] q;
  logic [7:0] seq [4] = '{8'h05, 8'h83, 8'h11, 8'h00};
  assign sda_w = sda_rel & (sda_oe_b_out | sda_out);
  haptic_waveform_sequencer #(.WAIT_UNIT_CYC(W)) dut (.clk_in(clk_in), .rst_b_in(rst_b_in), .scl_in(scl),
    .sda_in(sda_w), .enable_in(enable_in), .play_done_in(play_done_in), .sda_out(sda_out),
    .sda_oe_b_out(sda_oe_b_out), .out_float_out(out_float_out), .busy_out(busy_out), .play_cmd_out(play_cmd_out));
  hws_host host (.clk_in(clk_in), .sda_in(sda_w), .scl_out(scl), .sda_rel_out(sda_rel));
  task automatic end_of_test;
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : end_of_test
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    host.rd(a, q, ok);
    check("read ack", ok, 1'b1);
    check("read data", q, exp);
  endtask : rd_chk
  task automatic wr_chk(input logic [7:0] a, input logic [7:0] d);
    host.wr(BUS_DEV_ADDR, a, d, ok);
    check("write ack", ok, 1'b1);
  endtask : wr_chk
  task automatic go_idle;
    n_start = 0;
    wr_chk(ADDR_GO, 8'h01);
    repeat (4000) if (busy_out !== 1'b0) host.tick(1);
    check("idle", busy_out, 1'b0);
  endtask : go_idle
  initial
  begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end
  // playback engine: done after done_dly cycles, cut by abort
  always @(posedge clk_in)
  begin
    cyc++;
    play_done_in <= #1 (dly == 1);
    if (play_cmd_out.start === 1'b1)
    begin
      n_start++;
      last_cmd = play_cmd_out;
      t0 = t1;
      t1 = cyc;
      dly = done_dly;
    end
    else if (dly > 0)
      dly--;
    if (play_cmd_out.abort === 1'b1)
    begin
      n_abort++;
      dly = 0;
    end
    if (cyc == 90000)
    begin
      err_count++;
      end_of_test();
    end
  end
  initial
  begin
    rst_b_in = 1'b0;
    enable_in = 1'b1;
    play_done_in = 1'b0;
    done_dly = 4;
    repeat (8) @(posedge clk_in);
    #1 rst_b_in = 1'b1;
    rd_chk(ADDR_LIB_CTRL, LIB_CTRL_RESET);
    rd_chk(ADDR_SLOT_FIRST, SLOT_RESET);
    rd_chk(8'h20, 8'h00);
    host.wr(BUS_DEV_ADDR ^ 7'h01, ADDR_LIB_CTRL, 8'h16, ok);
    check("foreign target", ok, 1'b0);
    rd_chk(ADDR_LIB_CTRL, LIB_CTRL_RESET);
    wr_chk(ADDR_LIB_CTRL, 8'hef);
    rd_chk(ADDR_LIB_CTRL, 8'h07);
    wr_chk(ADDR_SLOT_FIRST, 8'h03);
    for (int l = 0; l < 8; l++)
    begin
      wr_chk(ADDR_LIB_CTRL, 8'(l));
      go_idle();
      check("starts", n_start, 32'(l % 7 != 0));
      if (l % 7 != 0) check("cmd", {last_cmd.lib, last_cmd.id}, {3'(l), 7'h03});
    end
    rd_chk(ADDR_GO, 8'h00);
    wr_chk(ADDR_LIB_CTRL, 8'h01);
    for (int i = 0; i < 4; i++)
      wr_chk(8'(ADDR_SLOT_FIRST + i), seq[i]);
    go_idle();
    check("starts", n_start, 2);
    check("id", last_cmd.id, 7'h11);
    check("wait", 32'(t1 - t0 >= done_dly + 3 * W && t1 - t0 <= done_dly + 3 * W + 8), 1);
    for (int i = 0; i < 8; i++)
      wr_chk(8'(ADDR_SLOT_FIRST + i), 8'(i + 1));
    go_idle();
    check("starts", n_start, 8);
    check("id", last_cmd.id, 7'h08);
    done_dly = 1500;
    wr_chk(ADDR_GO, 8'h01);
    rd_chk(ADDR_GO, 8'h01);
    n_abort = 0;
    wr_chk(ADDR_GO, 8'h00);
    host.tick(3);
    check("abort", n_abort, 1);
    check("busy", busy_out, 1'b0);
    wr_chk(ADDR_GO, 8'h01);
    wr_chk(ADDR_LIB_CTRL, 8'h16);
    check("float", out_float_out, 1'b1);
    check("abort", n_abort, 2);
    check("busy", busy_out, 1'b0);
    enable_in = 1'b0;
    host.tick(2);
    check("float", out_float_out, 1'b0);
    enable_in = 1'b1;
    host.tick(2);
    check("float", out_float_out, 1'b1);
    done_dly = 4;
    wr_chk(ADDR_LIB_CTRL, 8'h06);
    go_idle();
    end_of_test();
  end
endmodule : haptic_waveform_sequencer_tb_top
